// ---- hdl/sfpe_ctrl.sv ----
// Operation
// - opcodes 32h and 38h start a quad page program of up to 256 bytes.
// - a program aimed at a protected page is dropped, array untouched.
// - opcode on one line outside quad mode, then three address bytes and data bytes on four lines.
// - program starts only at chip select rise after a complete sequence.
// - while busy, every command but status read is ignored.
// - busy flag reads one while an operation runs, zero after.
// - beyond 256 bytes the column wraps; only the last 256 are kept.
// - start anywhere in a page, wrap to its start, unsent bytes unchanged.
// - program only clears bits; erase returns the region to all ones.
// - D7h or 20h with three address bytes erases one 4 Kbyte sector.
// - 52h erases 32 Kbyte, D8h 64 Kbyte, each after three address bytes.
// - C7h or 60h with no address erases the whole array, only while protect level is zero.
// - write enable latch clears when any write-type operation completes.
// - write enable latch is clear after power-up.
// - opcode 06h sets the write enable latch.
// - opcode 04h clears the write enable latch.
// - opcode 05h returns the status register including the busy flag.
// - opcode 01h writes protect level, status write protect and quad enable.
// - opcode 48h returns the function register.
// - opcode 42h sets top/bottom select and info row lock bits.
// - top/bottom select and lock bits, once one, never return to zero.
// - after quad mode entry every command uses four lines until exit.
`timescale 1ns/1ps
`include "sfpe_defs.svh"
module sfpe_ctrl
  import sfpe_pkg::*;
(
  input  wire logic        clk_i,          // 200 MHz core clock
  input  wire logic        srst_i,         // sync reset, high
  input  wire logic        sck_i,          // serial clock pin
  input  wire logic        cs_n_i,         // chip select pin, low active
  input  wire logic [3:0]  io_i,           // data pins in
  output logic      [3:0]  io_o,           // data pins out
  output logic      [3:0]  io_oe_o,        // data pin drive enables
  output logic             eng_start_o,    // one-cycle launch pulse
  output sfpe_op_t         eng_op_o,       // operation kind
  output logic      [23:0] eng_addr_o,     // target address
  input  wire logic [7:0]  eng_rd_addr_i,  // page buffer read column
  output logic      [7:0]  eng_rd_data_o,  // page byte, ff when unsent
  input  wire logic        eng_done_i,     // engine finished pulse
  output logic      [7:0]  status_o,       // status register view
  output logic      [7:0]  function_o,     // function register view
  output logic             quad_mode_o     // four-line command mode
);

  localparam logic [7:0] REGWR_CYC = 8'(`SFPE_REGWR_CYC);

  sfpe_state_t st_r;
  sfpe_cmd_t   cmd_r;
  sfpe_cmd_t   dec_cmd;
  sfpe_cmd_t   opc_cmd;
  sfpe_op_t    op_r;
  logic [1:0]  sck_s_r;
  logic [1:0]  cs_s_r;
  logic [3:0]  io_s1_r;
  logic [3:0]  io_s2_r;
  logic        sck_d_r;
  logic        cs_d_r;
  logic [7:0]  sh_r;
  logic [3:0]  bit_r;
  logic [1:0]  abyte_r;
  logic [23:0] addr_r;
  logic [7:0]  col_r;
  logic        have_data_r;
  logic [7:0]  data_r;
  logic [7:0]  out_r;
  logic [5:0]  sr_r;
  logic [7:0]  fr_r;
  logic        wel_r;
  logic        wip_r;
  logic        eng_run_r;
  logic [7:0]  tmr_r;
  logic        start_r;
  logic        quad_r;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; the link clock is sampled, not used as a clock

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sck_s_r <= 2'b00;
      cs_s_r  <= 2'b11;
      sck_d_r <= 1'b0;
      cs_d_r  <= 1'b1;
    end else begin
      sck_s_r <= {sck_s_r[0], sck_i};
      cs_s_r  <= {cs_s_r[0], cs_n_i};
      sck_d_r <= sck_s_r[1];
      cs_d_r  <= cs_s_r[1];
    end
  end

  // data pins take the same two stages, so they stay aligned with the clock
  always_ff @(posedge clk_i) begin
    io_s1_r <= io_i;
    io_s2_r <= io_s1_r;
  end

  wire sel      = ~cs_s_r[1];
  wire sck_rise = sck_s_r[1] & ~sck_d_r & sel;
  wire cs_rise  = cs_s_r[1] & ~cs_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // shifter: one line per edge, or four for quad mode and quad program

  wire       wide     = quad_r | (cmd_r == CMD_PROG);
  wire [7:0] sh_nxt   = wide ? {sh_r[3:0], io_s2_r} : {sh_r[6:0], io_s2_r[0]};
  wire [3:0] bit_nxt  = bit_r + (wide ? 4'h4 : 4'h1);
  wire       byte_end = sck_rise & (bit_nxt == 4'h8);
  wire       opc_end  = byte_end & (st_r == ST_OPC);

  always_ff @(posedge clk_i) begin
    if (srst_i || !sel) begin
      bit_r <= 4'h0;
    end else if (sck_rise) begin
      bit_r <= byte_end ? 4'h0 : bit_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sh_r <= 8'h00;
    end else if (sck_rise) begin
      sh_r <= sh_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // opcode decode

  assign dec_cmd =
    (sh_nxt == `SFPE_OPC_PROG_A || sh_nxt == `SFPE_OPC_PROG_B) ? CMD_PROG  :
    (sh_nxt == `SFPE_OPC_SECT_A || sh_nxt == `SFPE_OPC_SECT_B) ? CMD_SECT  :
    (sh_nxt == `SFPE_OPC_BLK32)                                ? CMD_BLK32 :
    (sh_nxt == `SFPE_OPC_BLK64)                                ? CMD_BLK64 :
    (sh_nxt == `SFPE_OPC_CHIP_A || sh_nxt == `SFPE_OPC_CHIP_B) ? CMD_CHIP  :
    (sh_nxt == `SFPE_OPC_WRITE_ENABLE_CMD)                                 ? CMD_WRITE_ENABLE_CMD  :
    (sh_nxt == `SFPE_OPC_WRITE_DISABLE_CMD)                                 ? CMD_WRITE_DISABLE_CMD  :
    (sh_nxt == `SFPE_OPC_STATUS_READ_CMD)                                 ? CMD_STATUS_READ_CMD  :
    (sh_nxt == `SFPE_OPC_FUNCTION_REG_READ_CMD)                                 ? CMD_FUNCTION_REG_READ_CMD  :
    (sh_nxt == `SFPE_OPC_STATUS_WRITE_CMD)                                 ? CMD_STATUS_WRITE_CMD  :
    (sh_nxt == `SFPE_OPC_FUNCTION_REG_WRITE_CMD)                                 ? CMD_FUNCTION_REG_WRITE_CMD  :
    (sh_nxt == `SFPE_OPC_QPI_IN)                               ? CMD_QIN   :
    (sh_nxt == `SFPE_OPC_QPI_OUT)                              ? CMD_QOUT  : CMD_NONE;

  // a busy device hears nothing but the status read
  assign opc_cmd = (wip_r && dec_cmd != CMD_STATUS_READ_CMD) ? CMD_NONE : dec_cmd;

  wire is_erase_addr = (cmd_r == CMD_SECT) | (cmd_r == CMD_BLK32) | (cmd_r == CMD_BLK64);

  wire [5:0] opc_st =
    (opc_cmd == CMD_PROG || opc_cmd == CMD_SECT ||
     opc_cmd == CMD_BLK32 || opc_cmd == CMD_BLK64)  ? ST_ADDR :
    (opc_cmd == CMD_STATUS_READ_CMD || opc_cmd == CMD_FUNCTION_REG_READ_CMD)    ? ST_OUT  :
    (opc_cmd == CMD_STATUS_WRITE_CMD || opc_cmd == CMD_FUNCTION_REG_WRITE_CMD)    ? ST_DATA :
    (opc_cmd == CMD_NONE)                           ? ST_IGN  : ST_DONE;

  ////////////////////////////////////////////////////////////////////////////
  // command sequencer; frame state restarts whenever chip select is high

  always_ff @(posedge clk_i) begin
    if (srst_i || !sel) begin
      st_r  <= ST_OPC;
      cmd_r <= CMD_NONE;
    end else if (byte_end) begin
      unique case (st_r)
        ST_OPC: begin
          st_r  <= sfpe_state_t'(opc_st);
          cmd_r <= opc_cmd;
        end
        ST_ADDR: begin
          if (abyte_r == 2'd2) begin
            st_r <= (cmd_r == CMD_PROG) ? ST_DATA : ST_DONE;
          end
        end
        ST_DATA: begin
          if (cmd_r != CMD_PROG) begin
            st_r <= ST_DONE;
          end
        end
        ST_OUT:  st_r <= ST_OUT;
        ST_DONE: begin
          st_r  <= ST_IGN;  // surplus clocks spoil the command
          cmd_r <= CMD_NONE;
        end
        ST_IGN:  st_r <= ST_IGN;
      endcase
    end
  end

  // address bytes arrive most significant first
  always_ff @(posedge clk_i) begin
    if (srst_i || !sel) begin
      abyte_r <= 2'd0;
    end else if (byte_end && st_r == ST_ADDR) begin
      abyte_r <= abyte_r + 2'd1;
      addr_r  <= {addr_r[15:0], sh_nxt};
    end
  end

  // page column starts at the sent byte and wraps inside the page
  wire buf_wr = byte_end & (st_r == ST_DATA) & (cmd_r == CMD_PROG);

  always_ff @(posedge clk_i) begin
    if (srst_i || !sel) begin
      have_data_r <= 1'b0;
    end else if (byte_end && st_r == ST_ADDR && abyte_r == 2'd2) begin
      col_r <= sh_nxt;
    end else if (buf_wr) begin
      col_r       <= col_r + 8'h01;
      have_data_r <= 1'b1;
    end
  end

  // register write payload
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      data_r <= 8'h00;
    end else if (byte_end && st_r == ST_DATA && cmd_r != CMD_PROG) begin
      data_r <= sh_nxt;
    end
  end

  sfpe_page_buf u_buf (
    .clk_i     (clk_i),
    .srst_i    (srst_i),
    .clr_i     (opc_end && opc_cmd == CMD_PROG),
    .wr_en_i   (buf_wr),
    .wr_addr_i (col_r),
    .wr_data_i (sh_nxt),
    .rd_addr_i (eng_rd_addr_i),
    .rd_data_o (eng_rd_data_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // protected area: level n guards 2^(n-1) 64 Kbyte blocks at top or bottom; levels 8 to 15 guard all 128

  wire [3:0] bp       = sr_r[`SFPE_SR_BP_HI-2:`SFPE_SR_BP_LO-2];  // sr_r holds status bits 7..2
  wire [7:0] prot_cnt = (bp == 4'h0) ? 8'h00 : (bp >= 4'h8) ? `SFPE_BLOCKS : (8'h01 << (bp - 4'h1));
  wire [7:0] blk      = {1'b0, addr_r[22:16]};
  wire       prot_hit = fr_r[`SFPE_FR_TBS] ? (blk < prot_cnt) : (blk >= (`SFPE_BLOCKS - prot_cnt));

  ////////////////////////////////////////////////////////////////////////////
  // execution at chip select rise; the latch is the last gate

  wire done_ok  = (st_r == ST_DONE) & (bit_r == 4'h0);  // a stray bit after the last byte spoils the frame
  wire go_prog  = (cmd_r == CMD_PROG) & (st_r == ST_DATA) & have_data_r & (bit_r == 4'h0)
                & sr_r[`SFPE_SR_QE-2] & ~prot_hit;
  wire go_erase = done_ok & ((is_erase_addr & ~prot_hit) | ((cmd_r == CMD_CHIP) & (bp == 4'h0)));
  wire go_reg   = done_ok & ((cmd_r == CMD_STATUS_WRITE_CMD) | (cmd_r == CMD_FUNCTION_REG_WRITE_CMD));
  wire exec     = cs_rise & ~wip_r & wel_r;
  wire launch   = exec & (go_prog | go_erase);
  wire reg_wr   = exec & go_reg;
  wire finish   = wip_r & ((eng_run_r & eng_done_i) | (tmr_r == 8'h01));

  wire [2:0] op_sel =
    (cmd_r == CMD_PROG)  ? OP_PROG  :
    (cmd_r == CMD_SECT)  ? OP_SECT  :
    (cmd_r == CMD_BLK32) ? OP_BLK32 :
    (cmd_r == CMD_BLK64) ? OP_BLK64 : OP_CHIP;

  // launch pulse toward the self-timed engine; erase fills with ones there
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      start_r    <= 1'b0;
      op_r       <= OP_PROG;
      eng_addr_o <= 24'h000000;
    end else begin
      start_r <= launch;
      if (launch) begin
        op_r       <= sfpe_op_t'(op_sel);
        eng_addr_o <= addr_r;
      end
    end
  end

  // busy flag and its source; a register write is timed locally
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wip_r     <= 1'b0;
      eng_run_r <= 1'b0;
      tmr_r     <= 8'h00;
    end else if (launch || reg_wr) begin
      wip_r     <= 1'b1;
      eng_run_r <= launch;
      tmr_r     <= reg_wr ? REGWR_CYC : 8'h00;
    end else begin
      if (finish) begin
        wip_r     <= 1'b0;
        eng_run_r <= 1'b0;
      end
      if (tmr_r != 8'h00) begin
        tmr_r <= tmr_r - 8'h01;
      end
    end
  end

  // write enable latch: set, clear, and self clear on completion
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wel_r <= 1'b0;
    end else if (finish) begin
      wel_r <= 1'b0;
    end else if (cs_rise && done_ok && !wip_r) begin
      if (cmd_r == CMD_WRITE_ENABLE_CMD) begin
        wel_r <= 1'b1;
      end else if (cmd_r == CMD_WRITE_DISABLE_CMD) begin
        wel_r <= 1'b0;
      end
    end
  end

  // status bits 7..2 and function register; lock bits only ever set
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sr_r <= 6'(`SFPE_SR_RST >> 2);
      fr_r <= `SFPE_FR_RST;
    end else if (reg_wr && cmd_r == CMD_STATUS_WRITE_CMD) begin
      sr_r <= data_r[7:2];
    end else if (reg_wr && cmd_r == CMD_FUNCTION_REG_WRITE_CMD) begin
      fr_r <= fr_r | (data_r & `SFPE_FR_OTP_MASK);
    end
  end

  // quad command mode entry and exit
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      quad_r <= 1'b0;
    end else if (cs_rise && done_ok && !wip_r) begin
      if (cmd_r == CMD_QIN) begin
        quad_r <= 1'b1;
      end else if (cmd_r == CMD_QOUT) begin
        quad_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read-out; bits change just after the rise the host sampled on

  wire [7:0] status_now = {sr_r, wel_r, wip_r};
  wire [7:0] rd_src     = (cmd_r == CMD_FUNCTION_REG_READ_CMD) ? fr_r : status_now;

  // status reloads each byte so polling sees the busy flag fall
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      out_r <= 8'h00;
    end else if (opc_end) begin
      out_r <= (dec_cmd == CMD_FUNCTION_REG_READ_CMD) ? fr_r : status_now;
    end else if (sck_rise && st_r == ST_OUT) begin
      out_r <= byte_end ? rd_src : (quad_r ? {out_r[3:0], 4'h0} : {out_r[6:0], 1'b0});
    end
  end

  wire drive = sel & (st_r == ST_OUT);

  assign io_o        = quad_r ? out_r[7:4] : {2'b00, out_r[7], 1'b0};
  assign io_oe_o     = drive ? (quad_r ? 4'hf : 4'h2) : 4'h0;
  assign eng_start_o = start_r;
  assign eng_op_o    = op_r;
  assign status_o    = status_now;
  assign function_o  = fr_r;
  assign quad_mode_o = quad_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  AST_WEL_RESET: assert property (@(posedge clk_i) srst_i |=> !wel_r && !wip_r)
    else $error("latch or busy set after reset");
  AST_START_AT_CS: assert property (@(posedge clk_i) disable iff (srst_i)
    eng_start_o |-> $past(cs_rise) && $past(cmd_r) != CMD_NONE)
    else $error("engine started without chip select rise");
  AST_START_NEEDS_WEL: assert property (@(posedge clk_i) disable iff (srst_i)
    eng_start_o |-> wel_r && $past(wel_r, 1))
    else $error("engine started with latch clear");
  AST_WIP_UP: assert property (@(posedge clk_i) disable iff (srst_i)
    eng_start_o |-> wip_r ##1 wip_r)
    else $error("busy flag missing while engine runs");
  AST_DONE_CLEARS: assert property (@(posedge clk_i) disable iff (srst_i)
    (wip_r && eng_run_r && eng_done_i) |=> !wip_r && !wel_r && status_o[1:0] == 2'b00)
    else $error("completion did not clear busy and latch");
  AST_BUSY_NO_START: assert property (@(posedge clk_i) disable iff (srst_i)
    $past(wip_r) && wip_r |-> !eng_start_o)
    else $error("new operation while busy");
  AST_WRITE_DISABLE_CMD: assert property (@(posedge clk_i) disable iff (srst_i)
    (cs_rise && done_ok && cmd_r == CMD_WRITE_DISABLE_CMD) |=> !wel_r)
    else $error("disable left latch set");
  AST_WRITE_ENABLE_CMD: assert property (@(posedge clk_i) disable iff (srst_i)
    (cs_rise && done_ok && cmd_r == CMD_WRITE_ENABLE_CMD && !wip_r) |=> wel_r)
    else $error("enable did not set latch");
  AST_OTP: assert property (@(posedge clk_i) disable iff (srst_i)
    (fr_r & `SFPE_FR_OTP_MASK) != 8'h00 |=> ((fr_r & $past(fr_r)) == $past(fr_r)))
    else $error("one-time bit returned to zero");
  AST_PROT: assert property (@(posedge clk_i) disable iff (srst_i)
    (eng_start_o && eng_op_o != OP_CHIP) |-> ##0 !prot_hit)
    else $error("operation launched into protected area");
  AST_REG_BUSY: assert property (@(posedge clk_i) disable iff (srst_i)
    reg_wr |=> wip_r [*8])
    else $error("register write not shown busy");

endmodule : sfpe_ctrl

// ---- hdl/sfpe_defs.svh ----
`ifndef SFPE_DEFS_SVH
`define SFPE_DEFS_SVH

// opcodes
`define SFPE_OPC_PROG_A   8'h32
`define SFPE_OPC_PROG_B   8'h38
`define SFPE_OPC_SECT_A   8'hd7
`define SFPE_OPC_SECT_B   8'h20
`define SFPE_OPC_BLK32    8'h52
`define SFPE_OPC_BLK64    8'hd8
`define SFPE_OPC_CHIP_A   8'hc7
`define SFPE_OPC_CHIP_B   8'h60
`define SFPE_OPC_WRITE_ENABLE_CMD     8'h06
`define SFPE_OPC_WRITE_DISABLE_CMD     8'h04
`define SFPE_OPC_STATUS_READ_CMD     8'h05
`define SFPE_OPC_STATUS_WRITE_CMD     8'h01
`define SFPE_OPC_FUNCTION_REG_READ_CMD     8'h48
`define SFPE_OPC_FUNCTION_REG_WRITE_CMD     8'h42
`define SFPE_OPC_QPI_IN   8'h35
`define SFPE_OPC_QPI_OUT  8'hf5

// status register fields
`define SFPE_SR_WIP       0
`define SFPE_SR_WEL       1
`define SFPE_SR_BP_LO     2
`define SFPE_SR_BP_HI     5
`define SFPE_SR_QE        6
`define SFPE_SR_STATUS_WRITE_PROTECT_BIT      7
`define SFPE_SR_RST       8'h00

// function register fields
`define SFPE_FR_TBS       1
`define SFPE_FR_OTP_MASK  8'hf2
`define SFPE_FR_RST       8'h00

// array geometry
`define SFPE_BLOCKS       8'h80

// timing
`define SFPE_CLK_NS       5
`define SFPE_T_REGWR_NS   1000
`define SFPE_REGWR_CYC    ((`SFPE_T_REGWR_NS + `SFPE_CLK_NS - 1) / `SFPE_CLK_NS)

`endif

// ---- hdl/sfpe_pkg.sv ----
package sfpe_pkg;

  typedef enum logic [5:0] {
    ST_OPC  = 6'b000001,
    ST_ADDR = 6'b000010,
    ST_DATA = 6'b000100,
    ST_OUT  = 6'b001000,
    ST_DONE = 6'b010000,
    ST_IGN  = 6'b100000
  } sfpe_state_t;

  typedef enum logic [3:0] {
    CMD_NONE, CMD_PROG, CMD_SECT, CMD_BLK32, CMD_BLK64, CMD_CHIP, CMD_WRITE_ENABLE_CMD,
    CMD_WRITE_DISABLE_CMD, CMD_STATUS_READ_CMD, CMD_FUNCTION_REG_READ_CMD, CMD_STATUS_WRITE_CMD, CMD_FUNCTION_REG_WRITE_CMD, CMD_QIN, CMD_QOUT
  } sfpe_cmd_t;

  typedef enum logic [2:0] {
    OP_PROG, OP_SECT, OP_BLK32, OP_BLK64, OP_CHIP
  } sfpe_op_t;

endpackage : sfpe_pkg

// ---- hdl/sfpe_page_buf.sv ----
`timescale 1ns/1ps
module sfpe_page_buf
  import sfpe_pkg::*;
(
  input  wire logic       clk_i,      // core clock
  input  wire logic       srst_i,     // sync reset, high
  input  wire logic       clr_i,      // forget all bytes of the page
  input  wire logic       wr_en_i,    // byte write strobe
  input  wire logic [7:0] wr_addr_i,  // byte column
  input  wire logic [7:0] wr_data_i,  // byte value
  input  wire logic [7:0] rd_addr_i,  // engine read column
  output logic      [7:0] rd_data_o   // registered read data
);

  logic [7:0]   mem_r [0:255];
  logic [255:0] vld_r;
  logic [7:0]   rd_r;

  // a later byte to the same column simply overwrites
  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem_r[wr_addr_i] <= wr_data_i;
    end
  end

  // which columns the host actually sent
  always_ff @(posedge clk_i) begin
    if (srst_i || clr_i) begin
      vld_r <= '0;
    end else if (wr_en_i) begin
      vld_r[wr_addr_i] <= 1'b1;
    end
  end

  // unsent columns read as all ones, so an and-type program leaves them alone
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rd_r <= 8'hff;
    end else begin
      rd_r <= vld_r[rd_addr_i] ? mem_r[rd_addr_i] : 8'hff;
    end
  end

  assign rd_data_o = rd_r;

endmodule : sfpe_page_buf

// ---- testbench/sfpe_host_model.sv ----
`timescale 1ns/1ps
// host end of the serial link; sck rests low between frames
module sfpe_host_model (
  input  wire logic       clk_i,   // bench clock
  input  wire logic [3:0] pin_i,   // resolved data pins
  output logic            sck_o,   // serial clock
  output logic            cs_n_o,  // chip select, low active
  output logic      [3:0] io_o,    // host data out
  output logic      [3:0] oe_o     // host drive enables
);
  initial begin
    sck_o  = 1'b0;
    cs_n_o = 1'b1;
    io_o   = 4'h0;
    oe_o   = 4'h0;
  end
  //////////////////////////////////////////////////////////////////////
  // every host change lands just after a core clock edge
  task automatic hc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : hc
  // one 160 ns period; sampled late in the low half, device drives after a rise
  task automatic cyc(input logic [3:0] v, input logic [3:0] en, output logic [3:0] r);
    io_o = v;
    oe_o = en;
    hc(16);
    r = pin_i;
    sck_o = 1'b1;
    hc(16);
    sck_o = 1'b0;
  endtask : cyc
  // msb first; quad moves a nibble a clock, a read leaves the pins released
  task automatic xb(input logic [7:0] b, input bit q, input bit rd, output logic [7:0] r);
    logic [3:0] t;
    for (int i = 0; i < (q ? 2 : 8); i++) begin
      cyc(q ? b[7-4*i -: 4] : {3'h0, b[7-i]}, rd ? 4'h0 : (q ? 4'hf : 4'h1), t);
      r = q ? {r[3:0], t} : {r[6:0], t[1]};
    end
  endtask : xb
  task automatic sel();
    cs_n_o = 1'b0;
    hc(4);
  endtask : sel
  // pins released before the rise; gap covers the launch delay
  task automatic desel();
    oe_o = 4'h0;
    hc(2);
    cs_n_o = 1'b1;
    hc(10);
  endtask : desel
endmodule : sfpe_host_model

// ---- testbench/tb_sfpe_ctrl.sv ----
`timescale 1ns/1ps
module tb_sfpe_ctrl
  import sfpe_pkg::*;
;
  logic        clk_i, srst_i, sck, cs_n, eng_start_o, eng_done_i, quad_mode_o;
  logic        flip = 1'b0;
  logic [3:0]  io_out, io_oe, h_io, h_oe, pins;
  logic [7:0]  eng_rd_addr_i, eng_rd_data_o, status_o, function_o, r;
  logic [7:0]  page [256];
  logic [23:0] eng_addr_o;
  sfpe_op_t    eng_op_o;
  int          fails = 0, n_compared = 0, starts = 0, n0, cyc_n = 0;
  bit          qm = 1'b0;
  logic [7:0]  eop [6] = '{8'hd7, 8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60};
  sfpe_op_t    ekind [6] = '{OP_SECT, OP_SECT, OP_BLK32, OP_BLK64, OP_CHIP, OP_CHIP};
  // an undriven pin toggles so a stale value never reads back
  assign pins = (io_oe & io_out) | (~io_oe & h_oe & h_io) | (~io_oe & ~h_oe & {4{flip}});
  sfpe_ctrl uut (.clk_i(clk_i), .srst_i(srst_i), .sck_i(sck), .cs_n_i(cs_n), .io_i(pins),
    .io_o(io_out), .io_oe_o(io_oe), .eng_start_o(eng_start_o), .eng_op_o(eng_op_o),
    .eng_addr_o(eng_addr_o), .eng_rd_addr_i(eng_rd_addr_i), .eng_rd_data_o(eng_rd_data_o),
    .eng_done_i(eng_done_i), .status_o(status_o), .function_o(function_o), .quad_mode_o(quad_mode_o));
  sfpe_host_model h (.clk_i(clk_i), .pin_i(pins), .sck_o(sck), .cs_n_o(cs_n), .io_o(h_io), .oe_o(h_oe));
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    flip <= ~flip;
    cyc_n++;
    if (cyc_n == 90000) begin
      fails++;
      wrap_up();
    end
  end
  //////////////////////////////////////////////////////////////////////
  // engine stand-in: copies the page, then stays busy long enough to poll
  initial begin
    eng_done_i = 1'b0;
    eng_rd_addr_i = 8'h00;
    forever begin
      @(posedge clk_i iff eng_start_o === 1'b1);
      starts++;
      #1;
      for (int c = 0; c < 256; c++) begin
        eng_rd_addr_i = c[7:0];
        h.hc(1);
        page[c] = eng_rd_data_o;
      end
      h.hc(2000);
      eng_done_i = 1'b1;
      h.hc(1);
      eng_done_i = 1'b0;
    end
  end
  //////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t: %s", $time, m);
      fails++;
    end
  endtask : chk
  function automatic logic [7:0] dv(input int k);
    return 8'(k * 7 + k / 256 * 85);
  endfunction : dv
  // whole frame: opcode then nb argument bytes, high byte first
  task automatic cmd(input logic [7:0] op, input int nb, input logic [23:0] arg);
    h.sel();
    h.xb(op, qm, 1'b0, r);
    for (int k = nb - 1; k >= 0; k--) h.xb(arg[8*k +: 8], qm, 1'b0, r);
    h.desel();
  endtask : cmd
  task automatic rd(input logic [7:0] op, output logic [7:0] v);
    h.sel();
    h.xb(op, qm, 1'b0, v);
    h.xb(8'h00, qm, 1'b1, v);
    h.desel();
  endtask : rd
  // bounded poll of the busy bit
  task automatic idle();
    r = 8'hff;
    for (int i = 0; i < 40 && r[0] !== 1'b0; i++) rd(8'h05, r);
    chk(r[0], 1'b0, "busy never dropped");
  endtask : idle
  // address and data always travel on four lines
  task automatic prog(input logic [7:0] op, input logic [23:0] a, input int n);
    h.sel();
    h.xb(op, qm, 1'b0, r);
    for (int k = 2; k >= 0; k--) h.xb(a[8*k +: 8], 1'b1, 1'b0, r);
    for (int k = 0; k < n; k++) h.xb(dv(k), 1'b1, 1'b0, r);
    h.desel();
  endtask : prog
  //////////////////////////////////////////////////////////////////////
  initial begin
    srst_i = 1'b1;
    h.hc(12);
    srst_i = 1'b0;
    h.hc(4);
    chk({status_o, function_o, quad_mode_o, io_oe}, 0, "reset values");
    n0 = starts;
    cmd(8'hc7, 0, 0);
    chk(starts, n0, "erase without latch");
    cmd(8'h06, 0, 0);
    rd(8'h05, r);
    chk(r, 8'h02, "latch read");
    cmd(8'h04, 0, 0);
    chk(status_o, 8'h00, "latch clear");
    cmd(8'h06, 0, 0);
    n0 = starts;
    prog(8'h32, 24'h000000, 1);
    chk(starts, n0, "program without quad enable");
    cmd(8'h06, 0, 0);
    cmd(8'h01, 1, 24'h40);
    idle();
    chk(status_o, 8'h40, "status write");
    cmd(8'h06, 0, 0);
    n0 = starts;
    h.sel();
    h.xb(8'hc7, 1'b0, 1'b0, r);
    h.cyc(4'h0, 4'h1, r[3:0]);
    h.desel();
    chk(starts, n0, "partial frame ran");
    $display("test latch and status done");
    for (int k = 0; k < 6; k++) begin
      cmd(8'h06, 0, 0);
      n0 = starts;
      cmd(eop[k], k < 4 ? 3 : 0, 24'h123456 + 24'(k));
      chk(starts, n0 + 1, "erase not launched");
      chk(eng_op_o, ekind[k], "erase kind");
      if (k < 4) chk(eng_addr_o, 24'h123456 + 24'(k), "erase address");
      rd(8'h05, r);
      chk(r[1:0], 2'b11, "busy not shown");
      cmd(8'h04, 0, 0);
      rd(8'h05, r);
      chk(r[1], 1'b1, "taken while busy");
      idle();
      chk(status_o[1:0], 2'b00, "latch after erase");
    end
    $display("test erase done");
    cmd(8'h06, 0, 0);
    n0 = starts;
    prog(8'h32, 24'h0100fe, 3);
    chk(starts, n0 + 1, "program not launched");
    chk({5'h0, eng_op_o, eng_addr_o}, {5'h0, OP_PROG, 24'h0100fe}, "program launch");
    idle();
    chk({page[254], page[255], page[0], page[1]}, {dv(0), dv(1), dv(2), 8'hff}, "page wrap");
    cmd(8'h06, 0, 0);
    prog(8'h38, 24'h020000, 258);
    idle();
    chk({page[0], page[1], page[2]}, {dv(256), dv(257), dv(2)}, "last bytes kept");
    cmd(8'h06, 0, 0);
    cmd(8'h01, 1, 24'h44);
    idle();
    cmd(8'h06, 0, 0);
    n0 = starts;
    prog(8'h32, 24'h7f0000, 1);
    chk(starts, n0, "protected page");
    $display("test program done");
    cmd(8'h06, 0, 0);
    cmd(8'h42, 1, 24'hf2);
    idle();
    cmd(8'h06, 0, 0);
    cmd(8'h42, 1, 24'h00);
    idle();
    rd(8'h48, r);
    chk(r, 8'hf2, "function bits");
    cmd(8'h35, 0, 0);
    qm = 1'b1;
    chk(quad_mode_o, 1'b1, "quad entry");
    rd(8'h05, r);
    chk(r, 8'h44, "quad status");
    cmd(8'hf5, 0, 0);
    qm = 1'b0;
    chk(quad_mode_o, 1'b0, "quad exit");
    $display("test function and quad done");
    wrap_up();
  end
endmodule : tb_sfpe_ctrl
